// file: ctl_bus_pkg.sv
// Overview of operation
// - Data falling while clock high is a start; slave begins a new transaction.
// - Data rising while clock high is a stop; slave ends the transaction.
// - Each unit is eight data bits plus one acknowledge: nine clocks.
// - Slave pulls data low on the ninth clock of each accepted byte.
// - Chip address bits 7 to 3 are zero, bit 2 is one.
// - Chip address bit 1 matches the strap pin; bit 0 is direction.
// - Register addresses 00h to 49h are acknowledged; others are refused.
// - First data byte goes to the address, later bytes to ascending addresses.
// - Address 00h plus 72 data bytes loads registers 00h to 47h.
// - Read: address write, register address, repeated start, address read, ack.
// - Slave sends register bytes; master acks; further bytes ascend.
// - Master not-acknowledge then stop returns slave to idle.
// - Ranges 06h-11h and 1Eh-47h are write-only.
// - Writing the gain register forwards it over the three-wire gain port.
// - Readback of register 15h returns twice the stored value.
`default_nettype none

package ctl_bus_pkg;

  localparam int         NUM_REGS      = 74;
  localparam logic [6:0] LAST_ADDR     = 7'h49;
  localparam logic [6:0] GAIN_ADDR     = 7'h49;
  localparam logic [6:0] DOUBLED_ADDR  = 7'h15;
  localparam logic [6:0] WO_A_LO       = 7'h06;
  localparam logic [6:0] WO_A_HI       = 7'h11;
  localparam logic [6:0] WO_B_LO       = 7'h1e;
  localparam logic [6:0] WO_B_HI       = 7'h47;
  localparam logic [4:0] DEV_ADDR_HIGH = 5'h00;
  localparam logic       DEV_ADDR_FIX  = 1'h1;
  localparam int         DEV_FIX_POS   = 2;
  localparam int         DEV_STRAP_POS = 1;
  localparam int         DEV_RW_POS    = 0;
  localparam logic [3:0] BYTE_BITS     = 4'h8;
  localparam logic [7:0] WO_FILL       = 8'hff;
  localparam logic [7:0] REG_RESET     = 8'h00;
  localparam logic [2:0] GAIN_LAST_BIT = 3'h7;

  typedef enum logic [2:0] {
    PH_IDLE,
    PH_DEV,
    PH_REG,
    PH_WR,
    PH_RD
  } phase_t;

  typedef struct packed {
    phase_t                     phase;
    phase_t                     next_phase;
    logic [3:0]                 bit_cnt;
    logic                       in_ack;
    logic [7:0]                 shift;
    logic [6:0]                 ptr;
    logic                       sda_oe;
    logic                       master_ack;
    logic                       scl_p;
    logic                       sda_p;
    logic                       bus_act;
    logic                       rd_act;
    logic                       gain_req;
    logic                       gain_pend;
    logic [7:0]                 gain_word;
    logic [NUM_REGS-1:0][7:0]   regs;
  } sys_state_t;

  typedef struct packed {
    logic       req_seen;
    logic       busy;
    logic [7:0] shift;
    logic [2:0] cnt;
    logic       sclk;
    logic       data;
    logic       enable;
    logic       ack;
  } link_state_t;

endpackage

// Two-stage synchroniser; only the second stage leaves the module
module sync_stages #(
  parameter int WIDTH = 1
) (
  input  wire logic             clk_in,
  input  wire logic [WIDTH-1:0] d_in,
  output logic      [WIDTH-1:0] q_out
);

  if (WIDTH < 1)
  begin : g_check
    $error("sync_stages needs WIDTH of at least 1");
  end

  logic [1:0][WIDTH-1:0] stage_r;

  always_ff @(posedge clk_in)
  begin
    stage_r <= {stage_r[0], d_in};
  end

  assign q_out = stage_r[1];

endmodule // sync_stages

`default_nettype wire

// file: ctl_bus_slave.sv
`default_nettype none

module ctl_bus_slave (
  input  wire logic                              clk_sys_in,
  input  wire logic                              rst_in,
  input  wire logic                              scl_in,
  input  wire logic                              sda_in,
  output logic                                   sda_out,
  output logic                                   sda_oe_out,
  input  wire logic                              addr_select_in,
  input  wire logic                              clk_gain_link_in,
  output logic                                   gain_sclk_out,
  output logic                                   gain_data_out,
  output logic                                   gain_enable_out,
  output logic                                   bus_active_out,
  output logic                                   read_mode_out,
  output logic [ctl_bus_pkg::NUM_REGS*8-1:0]     cfg_regs_out
);

  ctl_bus_pkg::sys_state_t  s_r;
  ctl_bus_pkg::sys_state_t  s_nxt;
  ctl_bus_pkg::link_state_t l_r;
  ctl_bus_pkg::link_state_t l_nxt;

  logic [2:0] pins_s;
  logic       scl_s;
  logic       sda_s;
  logic       strap_s;
  logic       gain_ack_s;
  logic       gain_req_l;
  logic       rst_l;

  logic       scl_rise;
  logic       scl_fall;
  logic       start_seen;
  logic       stop_seen;
  logic       dev_match;
  logic [7:0] rd_val;

  // Bus pins and strap are asynchronous to the system clock
  sync_stages #(
    .WIDTH (3)
  ) u_pin_sync (
    .clk_in (clk_sys_in),
    .d_in   ({scl_in, sda_in, addr_select_in}),
    .q_out  (pins_s)
  );

  assign scl_s   = pins_s[2];
  assign sda_s   = pins_s[1];
  assign strap_s = pins_s[0];

  sync_stages #(
    .WIDTH (1)
  ) u_ack_sync (
    .clk_in (clk_sys_in),
    .d_in   (l_r.ack),
    .q_out  (gain_ack_s)
  );

  sync_stages #(
    .WIDTH (2)
  ) u_link_sync (
    .clk_in (clk_gain_link_in),
    .d_in   ({s_r.gain_req, rst_in}),
    .q_out  ({gain_req_l, rst_l})
  );

  assign scl_rise   = scl_s & ~s_r.scl_p;
  assign scl_fall   = ~scl_s & s_r.scl_p;
  assign start_seen = scl_s & s_r.scl_p & s_r.sda_p & ~sda_s;
  assign stop_seen  = scl_s & s_r.scl_p & ~s_r.sda_p & sda_s;

  assign dev_match =
    (s_r.shift[7:3] == ctl_bus_pkg::DEV_ADDR_HIGH) &&
    (s_r.shift[ctl_bus_pkg::DEV_FIX_POS] == ctl_bus_pkg::DEV_ADDR_FIX) &&
    (s_r.shift[ctl_bus_pkg::DEV_STRAP_POS] == strap_s);

  // Byte returned for the current read pointer
  always_comb
  begin
    rd_val = ctl_bus_pkg::WO_FILL;
    if (s_r.ptr <= ctl_bus_pkg::LAST_ADDR)
    begin
      rd_val = s_r.regs[s_r.ptr];
    end
    if (((s_r.ptr >= ctl_bus_pkg::WO_A_LO) &&
         (s_r.ptr <= ctl_bus_pkg::WO_A_HI)) ||
        ((s_r.ptr >= ctl_bus_pkg::WO_B_LO) &&
         (s_r.ptr <= ctl_bus_pkg::WO_B_HI)))
    begin
      rd_val = ctl_bus_pkg::WO_FILL;
    end
    if (s_r.ptr == ctl_bus_pkg::DOUBLED_ADDR)
    begin
      rd_val = {s_r.regs[ctl_bus_pkg::DOUBLED_ADDR][6:0], 1'h0};
    end
  end

  // Two-wire engine in the system domain
  always_comb
  begin
    ctl_bus_pkg::phase_t ph;
    ph = ctl_bus_pkg::PH_IDLE;
    s_nxt = s_r;
    s_nxt.scl_p = scl_s;
    s_nxt.sda_p = sda_s;

    // Hand the held gain byte to the link once the last one is done
    if (s_r.gain_pend && (s_r.gain_req == gain_ack_s))
    begin
      s_nxt.gain_req  = ~s_r.gain_req;
      s_nxt.gain_word = s_r.regs[ctl_bus_pkg::GAIN_ADDR];
      s_nxt.gain_pend = 1'h0;
    end

    if (start_seen)
    begin
      s_nxt.phase   = ctl_bus_pkg::PH_DEV;
      s_nxt.bit_cnt = 4'h0;
      s_nxt.in_ack  = 1'h0;
      s_nxt.sda_oe  = 1'h0;
    end
    else if (stop_seen)
    begin
      s_nxt.phase  = ctl_bus_pkg::PH_IDLE;
      s_nxt.in_ack = 1'h0;
      s_nxt.sda_oe = 1'h0;
    end
    else if (s_r.phase != ctl_bus_pkg::PH_IDLE)
    begin
      if (scl_rise)
      begin
        if (s_r.in_ack)
        begin
          if (s_r.phase == ctl_bus_pkg::PH_RD)
          begin
            s_nxt.master_ack = ~sda_s;
          end
        end
        else if (s_r.bit_cnt < ctl_bus_pkg::BYTE_BITS)
        begin
          s_nxt.bit_cnt = 4'(s_r.bit_cnt + 4'h1);
          if (s_r.phase != ctl_bus_pkg::PH_RD)
          begin
            s_nxt.shift = {s_r.shift[6:0], sda_s};
          end
        end
      end
      else if (scl_fall)
      begin
        if (s_r.in_ack)
        begin
          // Ninth clock over: release and move on
          ph = s_r.next_phase;
          if ((s_r.phase == ctl_bus_pkg::PH_RD) && !s_r.master_ack)
          begin
            ph = ctl_bus_pkg::PH_IDLE;
          end
          s_nxt.phase   = ph;
          s_nxt.in_ack  = 1'h0;
          s_nxt.bit_cnt = 4'h0;
          s_nxt.sda_oe  = 1'h0;
          if (ph == ctl_bus_pkg::PH_RD)
          begin
            s_nxt.shift = rd_val;
            s_nxt.sda_oe = ~rd_val[7];
            s_nxt.ptr = 7'(s_r.ptr + 7'h01);
          end
        end
        else if (s_r.bit_cnt == ctl_bus_pkg::BYTE_BITS)
        begin
          // Eighth clock over: decide on the acknowledge
          s_nxt.in_ack     = 1'h1;
          s_nxt.next_phase = ctl_bus_pkg::PH_IDLE;
          s_nxt.sda_oe     = 1'h0;
          case (s_r.phase)
            ctl_bus_pkg::PH_DEV:
            begin
              if (dev_match)
              begin
                s_nxt.sda_oe = 1'h1;
                s_nxt.next_phase = s_r.shift[ctl_bus_pkg::DEV_RW_POS] ?
                                   ctl_bus_pkg::PH_RD :
                                   ctl_bus_pkg::PH_REG;
              end
            end
            ctl_bus_pkg::PH_REG:
            begin
              if (s_r.shift <= {1'h0, ctl_bus_pkg::LAST_ADDR})
              begin
                s_nxt.sda_oe     = 1'h1;
                s_nxt.ptr        = s_r.shift[6:0];
                s_nxt.next_phase = ctl_bus_pkg::PH_WR;
              end
            end
            ctl_bus_pkg::PH_WR:
            begin
              if (s_r.ptr <= ctl_bus_pkg::LAST_ADDR)
              begin
                s_nxt.sda_oe          = 1'h1;
                s_nxt.regs[s_r.ptr]   = s_r.shift;
                s_nxt.ptr             = 7'(s_r.ptr + 7'h01);
                s_nxt.next_phase      = ctl_bus_pkg::PH_WR;
                if (s_r.ptr == ctl_bus_pkg::GAIN_ADDR)
                begin
                  s_nxt.gain_pend = 1'h1;
                end
              end
            end
            ctl_bus_pkg::PH_RD:
            begin
              s_nxt.next_phase = ctl_bus_pkg::PH_RD;
            end
            default:
            begin
              s_nxt.next_phase = ctl_bus_pkg::PH_IDLE;
            end
          endcase
        end
        else if ((s_r.phase == ctl_bus_pkg::PH_RD) &&
                 (s_r.bit_cnt != 4'h0))
        begin
          s_nxt.shift  = {s_r.shift[6:0], 1'h0};
          s_nxt.sda_oe = ~s_r.shift[6];
        end
      end
    end

    if (rst_in)
    begin
      s_nxt            = '0;
      s_nxt.phase      = ctl_bus_pkg::PH_IDLE;
      s_nxt.next_phase = ctl_bus_pkg::PH_IDLE;
      s_nxt.scl_p      = 1'h1;
      s_nxt.sda_p      = 1'h1;
      s_nxt.regs       = {ctl_bus_pkg::NUM_REGS{ctl_bus_pkg::REG_RESET}};
    end
    // Status outputs registered alongside the phase
    s_nxt.bus_act = (s_nxt.phase != ctl_bus_pkg::PH_IDLE);
    s_nxt.rd_act  = (s_nxt.phase == ctl_bus_pkg::PH_RD);
  end

  always_ff @(posedge clk_sys_in)
  begin
    s_r <= s_nxt;
  end

  // Three-wire gain port on the link clock; gain_word holds still
  // between request and acknowledge toggles
  always_comb
  begin
    l_nxt = l_r;
    if (l_r.busy)
    begin
      if (!l_r.sclk)
      begin
        l_nxt.sclk = 1'h1;
      end
      else
      begin
        l_nxt.sclk = 1'h0;
        if (l_r.cnt == ctl_bus_pkg::GAIN_LAST_BIT)
        begin
          l_nxt.busy   = 1'h0;
          l_nxt.enable = 1'h0;
          l_nxt.data   = 1'h0;
          l_nxt.ack    = l_r.req_seen;
        end
        else
        begin
          l_nxt.cnt   = 3'(l_r.cnt + 3'h1);
          l_nxt.shift = {l_r.shift[6:0], 1'h0};
          l_nxt.data  = l_r.shift[6];
        end
      end
    end
    else if (gain_req_l != l_r.req_seen)
    begin
      l_nxt.req_seen = gain_req_l;
      l_nxt.busy     = 1'h1;
      l_nxt.enable   = 1'h1;
      l_nxt.shift    = s_r.gain_word;
      l_nxt.data     = s_r.gain_word[7];
      l_nxt.cnt      = 3'h0;
      l_nxt.sclk     = 1'h0;
    end
    if (rst_l)
    begin
      l_nxt = '0;
    end
  end

  always_ff @(posedge clk_gain_link_in)
  begin
    l_r <= l_nxt;
  end

  // Open-drain: only ever pulls low
  assign sda_out         = 1'h0;
  assign sda_oe_out      = s_r.sda_oe;
  assign gain_sclk_out   = l_r.sclk;
  assign gain_data_out   = l_r.data;
  assign gain_enable_out = l_r.enable;
  assign bus_active_out  = s_r.bus_act;
  assign read_mode_out   = s_r.rd_act;
  assign cfg_regs_out    = s_r.regs;

endmodule // ctl_bus_slave

`default_nettype wire

// file: ctl_bus_slave_monitor.sv
`default_nettype none
module ctl_bus_slave_monitor (
  input wire logic                               clk_sys_in,
  input wire logic                               rst_in,
  input wire logic                               scl_in,
  input wire logic                               sda_in,
  input wire logic                               sda_out,
  input wire logic                               sda_oe_out,
  input wire logic                               addr_select_in,
  input wire logic                               clk_gain_link_in,
  input wire logic                               gain_sclk_out,
  input wire logic                               gain_data_out,
  input wire logic                               gain_enable_out,
  input wire logic                               bus_active_out,
  input wire logic                               read_mode_out,
  input wire logic [ctl_bus_pkg::NUM_REGS*8-1:0] cfg_regs_out
);
  timeunit 1ns;
  timeprecision 100ps;
  default clocking @(posedge clk_sys_in);
  endclocking
  default disable iff (rst_in);
  a_pull_low: assert property (sda_oe_out |-> !sda_out)
    else $error("data line driven high");
  a_ack_hold: assert property ($rose(sda_oe_out) |-> sda_oe_out[*6])
    else $error("low level on data line too short");
  a_oe_window: assert property (
    $changed(sda_oe_out) |-> !scl_in && !$past(scl_in, 2))
    else $error("data line changed while bus clock high");
  a_start_opens: assert property (
    $fell(sda_in) && scl_in && $past(scl_in) |-> ##[1:6] bus_active_out)
    else $error("start not taken");
  a_stop_closes: assert property (
    $rose(sda_in) && scl_in && $past(scl_in)
    |-> ##[1:6] !bus_active_out && !read_mode_out)
    else $error("stop not taken");
  a_idle_quiet: assert property (!bus_active_out |-> !sda_oe_out)
    else $error("acknowledge while idle");
  a_read_in_bus: assert property (
    $rose(read_mode_out) |-> $past(bus_active_out))
    else $error("readback entered without chip address");
  a_regs_in_bus: assert property (
    $changed(cfg_regs_out) |-> bus_active_out && !read_mode_out)
    else $error("register changed outside write");
endmodule // ctl_bus_slave_monitor
bind ctl_bus_slave ctl_bus_slave_monitor i_mon (
  .clk_sys_in, .rst_in, .scl_in, .sda_in, .sda_out, .sda_oe_out,
  .addr_select_in, .clk_gain_link_in, .gain_sclk_out, .gain_data_out,
  .gain_enable_out, .bus_active_out, .read_mode_out, .cfg_regs_out
);
`default_nettype wire

// file: host_master_model.sv
`default_nettype none
module host_master_model (
  input  wire logic clk_in,
  input  wire logic sda_in,
  output var logic  scl_out,
  output var logic  sda_low_out,
  output var logic  transmit_burst_gate_out
);
  timeunit 1ns;
  timeprecision 100ps;
  initial
  begin
    scl_out = 1'b1;
    sda_low_out = 1'b0;
    // Burst gate stays low while the host owns the control bus
    transmit_burst_gate_out = 1'b0;
  end
  // Each pin change is held for six system cycles
  task automatic step(input logic c, input logic l);
    @(negedge clk_in);
    scl_out = c;
    sda_low_out = l;
    repeat (6) @(negedge clk_in);
  endtask
  task automatic clk_bit(input logic low, output logic seen);
    step(1'b0, low);
    step(1'b1, low);
    seen = sda_in;
    scl_out = 1'b0;
  endtask
  task automatic start_cond();
    step(scl_out, 1'b0);
    step(1'b1, 1'b0);
    step(1'b1, 1'b1);
    scl_out = 1'b0;
  endtask
  task automatic stop_cond();
    step(1'b0, 1'b1);
    step(1'b1, 1'b1);
    step(1'b1, 1'b0);
  endtask
  // Line released on the ninth clock for the answer
  task automatic put_byte(input logic [7:0] b, output logic ack);
    logic s;
    for (int i = 7; i >= 0; i--)
      clk_bit(!b[i], s);
    clk_bit(1'b0, s);
    ack = !s;
  endtask
  task automatic get_byte(input logic last, output logic [7:0] b);
    logic s;
    for (int i = 7; i >= 0; i--)
      clk_bit(1'b0, b[i]);
    clk_bit(!last, s);
  endtask
endmodule // host_master_model
`default_nettype wire

// file: test_ctl_bus_slave.sv
`default_nettype none
module test_ctl_bus_slave;
  timeunit 1ns;
  timeprecision 100ps;
  logic                               clk_sys_in = 1'b0;
  logic                               clk_gain_link_in = 1'b0;
  logic                               rst_in = 1'b1;
  logic                               addr_select_in;
  logic                               scl_in, m_low, sda_out, sda_oe_out;
  logic                               gain_sclk_out, gain_data_out;
  logic                               gain_enable_out, bus_active_out;
  logic                               read_mode_out;
  logic                               burst_gate;
  logic [ctl_bus_pkg::NUM_REGS*8-1:0] cfg_regs_out;
  logic [7:0]                         mem [0:73];
  logic [7:0]                         gain_cap;
  logic [3:0]                         gain_cnt;
  int                                 seed = 32194;
  int                                 bad_count = 0;
  int                                 samples_checked = 0;
  wire logic                          sda_in = ~(m_low | (sda_oe_out & ~sda_out));

  always #10 clk_sys_in = ~clk_sys_in;
  always #7.5 clk_gain_link_in = ~clk_gain_link_in;

  ctl_bus_slave i_dut (
    .clk_sys_in, .rst_in, .scl_in, .sda_in, .sda_out, .sda_oe_out,
    .addr_select_in, .clk_gain_link_in, .gain_sclk_out, .gain_data_out,
    .gain_enable_out, .bus_active_out, .read_mode_out, .cfg_regs_out
  );
  host_master_model i_host (
    .clk_in(clk_sys_in), .sda_in, .scl_out(scl_in), .sda_low_out(m_low),
    .transmit_burst_gate_out(burst_gate)
  );

  always @(posedge gain_sclk_out)
    if (gain_enable_out)
    begin
      gain_cap <= {gain_cap[6:0], gain_data_out};
      gain_cnt <= gain_cnt + 4'h1;
    end

  task automatic check_val(input logic [7:0] got, input logic [7:0] exp);
    samples_checked++;
    if (got !== exp)
    begin
      bad_count++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic final_report();
    if (bad_count == 0 && samples_checked > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask
  function automatic logic [7:0] chip(input logic rd);
    return {ctl_bus_pkg::DEV_ADDR_HIGH, ctl_bus_pkg::DEV_ADDR_FIX,
            addr_select_in, rd};
  endfunction
  function automatic logic [7:0] exp_rd(input logic [7:0] a);
    if ((a >= 8'h06 && a <= 8'h11) || (a >= 8'h1e && a <= 8'h47))
      return ctl_bus_pkg::WO_FILL;
    if (a == 8'h15)
      return {mem[a][6:0], 1'b0};
    return mem[a];
  endfunction
  task automatic check_regs();
    for (int r = 0; r < 74; r++)
      check_val(cfg_regs_out[8*r +: 8], mem[r]);
  endtask
  task automatic wr_burst(input logic [7:0] ra, input int n);
    logic       a;
    logic [7:0] d;
    i_host.start_cond();
    i_host.put_byte(chip(1'b0), a);
    check_val({7'h00, a}, 8'h01);
    i_host.put_byte(ra, a);
    check_val({7'h00, a}, 8'h01);
    for (int k = 0; k < n; k++)
    begin
      d = 8'($random(seed));
      i_host.put_byte(d, a);
      check_val({7'h00, a}, 8'h01);
      mem[ra + 8'(k)] = d;
    end
    i_host.stop_cond();
    check_val({7'h00, bus_active_out}, 8'h00);
    check_regs();
  endtask
  task automatic rd_burst(input logic [7:0] ra, input int n);
    logic       a;
    logic [7:0] d;
    i_host.start_cond();
    i_host.put_byte(chip(1'b0), a);
    i_host.put_byte(ra, a);
    check_val({7'h00, a}, 8'h01);
    i_host.start_cond();
    i_host.put_byte(chip(1'b1), a);
    // Readback phase starts a few cycles after the ninth clock falls
    repeat (4) @(negedge clk_sys_in);
    check_val({6'h00, a, read_mode_out}, 8'h03);
    for (int k = 0; k < n; k++)
    begin
      i_host.get_byte(k == n - 1, d);
      check_val(d, exp_rd(ra + 8'(k)));
    end
    i_host.stop_cond();
    check_val({6'h00, bus_active_out, read_mode_out}, 8'h00);
  endtask
  task automatic refused(input logic [7:0] ca, input logic [7:0] ra);
    logic a;
    i_host.start_cond();
    i_host.put_byte(ca, a);
    if (ca === chip(1'b0))
      i_host.put_byte(ra, a);
    check_val({7'h00, a}, 8'h00);
    i_host.stop_cond();
  endtask

  initial
  begin
    addr_select_in = 1'($random(seed));
    foreach (mem[i])
      mem[i] = 8'h00;
    repeat (10) @(negedge clk_sys_in);
    rst_in = 1'b0;
    repeat (3) wr_burst(8'($random(seed)) & 8'h3f, 1 + ($random(seed) & 3));
    wr_burst(8'h00, 72);
    gain_cnt = 4'h0;
    wr_burst(8'h49, 1);
    for (int k = 0; k < 200 && (gain_cnt != 4'h8 || gain_enable_out); k++)
      @(posedge clk_sys_in);
    check_val({4'h0, gain_cnt}, 8'h08);
    check_val(gain_cap, mem[73]);
    refused(chip(1'b0) ^ 8'h02, 8'h00);
    refused(chip(1'b0) ^ 8'h80, 8'h00);
    refused(chip(1'b0) ^ 8'h04, 8'h00);
    refused(chip(1'b0), 8'h4a | 8'($random(seed)));
    rd_burst(8'h12, 4);
    rd_burst(8'h04, 3);
    rd_burst(8'h49, 1);
    rd_burst(8'h46, 2);
    rd_burst(8'($random(seed)) & 8'h0f, 2);
    @(negedge clk_sys_in);
    rst_in = 1'b1;
    repeat (10) @(negedge clk_sys_in);
    rst_in = 1'b0;
    foreach (mem[i])
      mem[i] = 8'h00;
    check_regs();
    final_report();
  end
  initial
  begin
    repeat (60000) @(posedge clk_sys_in);
    bad_count++;
    final_report();
  end
endmodule // test_ctl_bus_slave
`default_nettype wire
